// [ash_defs.svh]
// constants of the auto-detecting serial host port
// included by the port module only
`ifndef ASH_DEFS_SVH
`define ASH_DEFS_SVH
`define ASH_LAST_BIT 5'h17
`define ASH_READ_FLAG 1'b1
`define ASH_ADDR_HI 4'h9
`define ASH_GC_ADDR 8'h00
`define ASH_GC_RESET 8'h06
`define ASH_BYTE_BITS 4'h8
`define ASH_BYTE_LAST 4'h7
`endif

// [ash_pkg.sv]
// types of the auto-detecting serial host port
// no surroundings assumed
package ash_pkg;
  typedef enum logic [2:0] {
    ASH_IF_NONE = 3'h1,
    ASH_IF_SPI = 3'h2,
    ASH_IF_I2C = 3'h4
  } ash_iface_t;
  typedef enum logic [4:0] {
    ASH_I_IDLE = 5'h01,
    ASH_I_RX = 5'h02,
    ASH_I_ACK = 5'h04,
    ASH_I_TX = 5'h08,
    ASH_I_TACK = 5'h10
  } ash_i2c_st_t;
  typedef struct packed {
    logic frame_sel_n;
    logic sclk;
    logic sdi;
    logic scl;
    logic sda;
  } ash_pins_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [15:0] data;
  } ash_reg_req_t;
  typedef struct packed {
    ash_pins_t s1;
    ash_pins_t s2;
    ash_pins_t s3;
    ash_pins_t flt;
    ash_iface_t iface;
    logic [4:0] bcnt;
    logic full;
    logic [23:0] sh;
    logic [23:0] first;
    logic [23:0] tx;
    logic [23:0] resp;
    logic [7:0] cmd;
    logic rd_pend;
    ash_i2c_st_t ist;
    logic [3:0] ibit;
    logic [7:0] ish;
    logic [1:0] ibyte;
    logic gc;
    logic irw;
    logic act;
    logic [15:0] itx;
    ash_reg_req_t req;
    logic sdo;
    logic sdo_oe;
    logic sda_o;
    logic sda_oe;
    logic swrst;
  } ash_state_t;
endpackage

// [ash_host_port.sv]
// serial host port: locks onto spi or i2c target, feeds a register request port
// assumes registers answer rd_data_in in the cycle after the read request pulse
// How it works
// - first protocol seen after reset is kept until the next reset
// - frame starts when select falls; input sampled on falling sclk
// - frames with fewer than 24 falling edges are dropped
// - three-wire frames use only the first 24 bits
// - select high blocks sclk and sdi and floats sdo
// - first byte holds read flag and 7-bit address, then 16 data bits
// - sdo stays off until the readback enable is set
// - four-wire needs the gpio mapped as sdo output
// - readback frame echoes flag, address, then register data
// - sdo launches on falling or rising sclk per edge select
// - four-wire uses last 24 bits; non-multiples of 24 dropped
// - only 7-bit i2c addresses answered
// - general call 0x06 resets on rising edge of its ack
// - receiver holds sda low through ninth clock high
// - standard, fast and fast-plus rates served alike
// - target receives writes and transmits on reads
// - i2c address is 1001 plus three select pin bits
// - i2c write applied on falling edge of last data ack
`timescale 1ns/1ps
`default_nettype none
`include "ash_defs.svh"
module ash_host_port (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire ash_pkg::ash_pins_t link_pins_in,
  input wire logic readback_output_enable_in,
  input wire logic output_edge_select_in,
  input wire logic gpio_sdo_map_in,
  input wire logic [2:0] address_select_pin_in,
  input wire logic [15:0] rd_data_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic sda_out,
  output logic sda_oe_out,
  output ash_pkg::ash_reg_req_t reg_req_out,
  output logic sw_reset_out,
  output ash_pkg::ash_iface_t iface_out
);
  import ash_pkg::*;
  ash_state_t st_reg;
  ash_state_t st_next;
  logic four;
  assign four = readback_output_enable_in & gpio_sdo_map_in;

  always_comb begin
    ash_pins_t nf;
    ash_pins_t pf;
    logic fs_fall;
    logic fs_rise;
    logic ck_fall;
    logic ck_rise;
    logic scl_rise;
    logic scl_fall;
    logic i2c_start;
    logic i2c_stop;
    logic launch;
    logic [23:0] word;
    nf = '0;
    pf = st_reg.flt;
    word = '0;
    launch = 1'b0;
    st_next = st_reg;
    st_next.req.wr = 1'b0;
    st_next.req.rd = 1'b0;
    st_next.swrst = 1'b0;
    st_next.sda_o = 1'b0;
    // three stages; a change counts once stages two and three agree
    st_next.s1 = link_pins_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.flt = ash_pins_t'((st_reg.s3 & ~(st_reg.s2 ^ st_reg.s3)) | (pf & (st_reg.s2 ^ st_reg.s3)));
    nf = st_next.flt;
    fs_fall = pf.frame_sel_n & ~nf.frame_sel_n;
    fs_rise = ~pf.frame_sel_n & nf.frame_sel_n;
    ck_fall = pf.sclk & ~nf.sclk;
    ck_rise = ~pf.sclk & nf.sclk;
    scl_rise = ~pf.scl & nf.scl;
    scl_fall = pf.scl & ~nf.scl;
    i2c_start = pf.scl & nf.scl & pf.sda & ~nf.sda;
    i2c_stop = pf.scl & nf.scl & ~pf.sda & nf.sda;
    // register data stands the cycle after the read pulse, so capture one cycle later
    st_next.rd_pend = st_reg.req.rd;
    if (st_reg.rd_pend) begin
      st_next.resp = {st_reg.cmd, rd_data_in};
    end
    // once chosen, the other protocol is never looked at again
    if (st_reg.iface == ASH_IF_NONE) begin
      if (fs_fall) begin
        st_next.iface = ASH_IF_SPI;
      end else if (i2c_start) begin
        st_next.iface = ASH_IF_I2C;
      end
    end
    if (st_next.iface == ASH_IF_SPI) begin
      if (fs_fall) begin
        st_next.bcnt = '0;
        st_next.full = 1'b0;
        st_next.tx = st_reg.resp;
        st_next.sdo = st_reg.resp[23];
      end else if (!nf.frame_sel_n) begin
        if (ck_fall) begin
          st_next.sh = {st_reg.sh[22:0], nf.sdi};
          if (st_reg.bcnt == `ASH_LAST_BIT) begin
            st_next.bcnt = '0;
            st_next.full = 1'b1;
            if (!st_reg.full) begin
              st_next.first = st_next.sh;
            end
          end else begin
            st_next.bcnt = st_reg.bcnt + 5'h01;
          end
        end
        // rising launch waits for the first sample so bit 23 is not skipped
        launch = output_edge_select_in ? ck_fall : (ck_rise & (st_reg.full | (st_reg.bcnt != '0)));
        if (launch) begin
          // newest input bit follows, so a chained part sees our frame 24 edges late
          st_next.tx = {st_reg.tx[22:0], st_next.sh[0]};
          st_next.sdo = st_reg.tx[22];
        end
      end
      if (fs_rise) begin
        word = four ? st_reg.sh : st_reg.first;
        if (st_reg.full && (!four || st_reg.bcnt == '0)) begin
          st_next.req.rd = (word[23] == `ASH_READ_FLAG);
          st_next.req.wr = (word[23] != `ASH_READ_FLAG);
          st_next.req.addr = word[22:16];
          st_next.req.data = word[15:0];
          if (word[23] == `ASH_READ_FLAG) begin
            st_next.cmd = word[23:16];
          end
        end
      end
    end
    st_next.sdo_oe = (st_next.iface == ASH_IF_SPI) & four & ~nf.frame_sel_n;
    // plain edge sampling at 40 mhz covers all three bus rates
    if (st_next.iface == ASH_IF_I2C) begin
      if (i2c_start) begin
        st_next.ist = ASH_I_RX;
        st_next.ibit = '0;
        st_next.ibyte = '0;
        st_next.act = 1'b0;
        st_next.sda_oe = 1'b0;
      end else if (i2c_stop) begin
        st_next.ist = ASH_I_IDLE;
        st_next.sda_oe = 1'b0;
      end else begin
        case (st_reg.ist)
          ASH_I_IDLE: begin
            st_next.sda_oe = 1'b0;
          end
          ASH_I_RX: begin
            if (scl_rise) begin
              st_next.ish = {st_reg.ish[6:0], nf.sda};
              st_next.ibit = st_reg.ibit + 4'h1;
            end else if (scl_fall && st_reg.ibit == `ASH_BYTE_BITS) begin
              st_next.ist = ASH_I_ACK;
              st_next.sda_oe = 1'b1;
              st_next.ibyte = (st_reg.ibyte == 2'h3) ? 2'h3 : st_reg.ibyte + 2'h1;
              case (st_reg.ibyte)
                2'h0: begin
                  if (st_reg.ish[7:1] == {`ASH_ADDR_HI, address_select_pin_in}) begin
                    st_next.gc = 1'b0;
                    st_next.irw = st_reg.ish[0];
                    if (st_reg.ish[0]) begin
                      st_next.req.rd = 1'b1;
                      st_next.req.addr = st_reg.cmd[6:0];
                    end
                  end else if (st_reg.ish == `ASH_GC_ADDR) begin
                    st_next.gc = 1'b1;
                    st_next.irw = 1'b0;
                  end else begin
                    st_next.ist = ASH_I_IDLE;
                    st_next.sda_oe = 1'b0;
                  end
                end
                2'h1: begin
                  if (!st_reg.gc) begin
                    st_next.cmd = st_reg.ish;
                  end else if (st_reg.ish == `ASH_GC_RESET) begin
                    st_next.act = 1'b1;
                  end else begin
                    st_next.ist = ASH_I_IDLE;
                    st_next.sda_oe = 1'b0;
                  end
                end
                2'h2: begin
                  st_next.itx[15:8] = st_reg.ish;
                end
                default: begin
                  st_next.itx[7:0] = st_reg.ish;
                  st_next.act = ~st_reg.gc;
                end
              endcase
            end
          end
          ASH_I_ACK: begin
            if (scl_rise && st_reg.act && st_reg.gc) begin
              st_next.swrst = 1'b1;
              st_next.act = 1'b0;
            end else if (scl_fall) begin
              st_next.ibit = '0;
              st_next.act = 1'b0;
              if (st_reg.act && !st_reg.gc) begin
                st_next.req.wr = 1'b1;
                st_next.req.addr = st_reg.cmd[6:0];
                st_next.req.data = st_reg.itx;
              end
              if (st_reg.irw) begin
                st_next.ist = ASH_I_TX;
                st_next.itx = st_reg.resp[15:0];
                st_next.sda_oe = ~st_reg.resp[15];
              end else begin
                st_next.ist = ASH_I_RX;
                st_next.sda_oe = 1'b0;
              end
            end
          end
          ASH_I_TX: begin
            if (scl_fall) begin
              st_next.ibit = st_reg.ibit + 4'h1;
              st_next.itx = {st_reg.itx[14:0], 1'b0};
              if (st_reg.ibit == `ASH_BYTE_LAST) begin
                st_next.ist = ASH_I_TACK;
                st_next.sda_oe = 1'b0;
              end else begin
                st_next.sda_oe = ~st_reg.itx[14];
              end
            end
          end
          ASH_I_TACK: begin
            if (scl_rise && nf.sda) begin
              st_next.ist = ASH_I_IDLE;
            end else if (scl_fall) begin
              st_next.ist = ASH_I_TX;
              st_next.ibit = '0;
              st_next.sda_oe = ~st_reg.itx[15];
            end
          end
          default: begin
            st_next.ist = ASH_I_IDLE;
            st_next.sda_oe = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_reg <= '0;
      st_reg.s1 <= '1;
      st_reg.s2 <= '1;
      st_reg.s3 <= '1;
      st_reg.flt <= '1;
      st_reg.iface <= ASH_IF_NONE;
      st_reg.ist <= ASH_I_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sdo_out = st_reg.sdo;
  assign sdo_oe_out = st_reg.sdo_oe;
  assign sda_out = st_reg.sda_o;
  assign sda_oe_out = st_reg.sda_oe;
  assign reg_req_out = st_reg.req;
  assign sw_reset_out = st_reg.swrst;
  assign iface_out = st_reg.iface;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  AST_IFACE_LOCK: assert property ((st_reg.iface != ASH_IF_NONE) |=> $stable(st_reg.iface))
    else $error("interface type changed after lock");
  AST_SDO_HIZ: assert property (st_reg.sdo_oe |-> !st_reg.flt.frame_sel_n)
    else $error("sdo driven while select high");
  AST_SDO_ENABLE: assert property (st_reg.sdo_oe |-> $past(four))
    else $error("sdo driven without readback enable and gpio map");
  AST_SHORT_DROP: assert property ((st_reg.iface == ASH_IF_SPI && $rose(st_reg.flt.frame_sel_n)
      && !$past(st_reg.full)) |-> !(st_reg.req.wr || st_reg.req.rd))
    else $error("short spi frame acted on");
  AST_DAISY_MULT: assert property ((st_reg.iface == ASH_IF_SPI && $rose(st_reg.flt.frame_sel_n)
      && $past(four)) |-> ((st_reg.req.wr || st_reg.req.rd)
      == ($past(st_reg.full) && $past(st_reg.bcnt) == '0)))
    else $error("four-wire frame length check wrong");
  AST_FIRST24: assert property ((st_reg.iface == ASH_IF_SPI && st_reg.req.wr && !$past(four))
      |-> st_reg.req.data == $past(st_reg.first[15:0]))
    else $error("three-wire write not from first 24 bits");
  AST_LAST24: assert property ((st_reg.iface == ASH_IF_SPI && st_reg.req.wr && $past(four))
      |-> st_reg.req.data == $past(st_reg.sh[15:0]))
    else $error("four-wire write not from last 24 bits");
  AST_ACK_LOW: assert property ((st_reg.ist == ASH_I_ACK && st_reg.flt.scl)
      |-> st_reg.sda_oe && !st_reg.sda_o)
    else $error("ack not held low in clock high");
  AST_GC_RISE: assert property (st_reg.swrst |-> st_reg.gc && st_reg.flt.scl && !$past(st_reg.flt.scl))
    else $error("general call reset off the ack rising edge");
  AST_I2C_WR_FALL: assert property ((st_reg.iface == ASH_IF_I2C && st_reg.req.wr)
      |-> !st_reg.flt.scl && $past(st_reg.flt.scl) && $past(st_reg.ist) == ASH_I_ACK)
    else $error("i2c write not on ack falling edge");
  COV_SPI_WRITE: cover property (st_reg.iface == ASH_IF_SPI && st_reg.req.wr);
  COV_SPI_READ: cover property (st_reg.iface == ASH_IF_SPI && st_reg.sdo_oe && st_reg.rd_pend == 1'b0);
  COV_I2C_WRITE: cover property (st_reg.iface == ASH_IF_I2C && st_reg.req.wr);
  COV_GC_RESET: cover property (st_reg.swrst);
endmodule
`default_nettype wire

// [ash_host_model.sv]
// far-side model: spi host and i2c controller, each transfer a task
// assumes one task runs at a time and is entered just after a core clock edge
`timescale 1ns/1ps
`default_nettype none
module ash_host_model (
  input wire logic core_clk_in,
  input wire logic sdo_in,
  input wire logic sdo_oe_in,
  input wire logic sda_oe_in,
  output ash_pkg::ash_pins_t pins_out
);
  import ash_pkg::*;
  logic fs_reg = 1'b1;
  logic sclk_reg = 1'b1;
  logic sdi_reg = 1'b0;
  logic scl_reg = 1'b1;
  logic pull_reg = 1'b0;
  logic sda_line;
  // open drain with pull-up: low while either party pulls
  assign sda_line = ~(pull_reg | sda_oe_in);
  assign pins_out = '{frame_sel_n: fs_reg, sclk: sclk_reg, sdi: sdi_reg, scl: scl_reg, sda: sda_line};
  task automatic w(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  // sclk rests high between frames; sdi flips once released
  task automatic spi(input logic [23:0] d, input int n, input int lead, input int hp, output logic [23:0] rx);
    int j;
    rx = '0;
    fs_reg <= 1'b0;
    for (int i = 0; i < n; i++) begin
      j = i - lead;
      sdi_reg <= (j >= 0 && j < 24) ? d[23 - j] : 1'($urandom); // msb first
      w(hp);
      rx = {rx[22:0], sdo_oe_in ? sdo_in : 1'bx};
      sclk_reg <= 1'b0;
      w(hp);
      sclk_reg <= 1'b1;
    end
    w(hp);
    fs_reg <= 1'b1;
    sdi_reg <= ~sdi_reg;
    w(12);
  endtask
  // controller makes scl and all conditions
  task automatic ibit(input logic d, input int hp, output logic r);
    scl_reg <= 1'b0;
    w(hp / 2);
    pull_reg <= ~d;
    w(hp / 2);
    scl_reg <= 1'b1;
    w(hp / 2);
    r = sda_line;
    w(hp / 2);
  endtask
  task automatic istart(input logic rep, input int hp);
    if (rep) begin
      scl_reg <= 1'b0;
      w(hp / 2);
      pull_reg <= 1'b0;
      w(hp / 2);
      scl_reg <= 1'b1;
      w(hp / 2);
    end
    pull_reg <= 1'b1;
    w(hp / 2);
  endtask
  task automatic istop(input int hp);
    scl_reg <= 1'b0;
    w(hp / 2);
    pull_reg <= 1'b1;
    w(hp / 2);
    scl_reg <= 1'b1;
    w(hp / 2);
    pull_reg <= 1'b0;
    w(hp);
  endtask
  task automatic iwr(input logic [7:0] b, input int hp, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) ibit(b[i], hp, r);
    ibit(1'b1, hp, r);
    ack = ~r;
  endtask
  task automatic ird(input logic ack, input int hp, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      ibit(1'b1, hp, r);
      b[i] = r;
    end
    ibit(~ack, hp, r); // controller answers as receiver
  endtask
endmodule
`default_nettype wire

// [auto_detect_serial_host_port_tb.sv]
// self-checking bench: spi phase, then a second reset and an i2c phase
// assumes registers answer reads with rdv() of the requested address
`timescale 1ns/1ps
`default_nettype none
module auto_detect_serial_host_port_tb;
  import ash_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, rbe = 1'b0, oes = 1'b0, gmap = 1'b0, sdo, sdo_oe, sda_oe, swr, sda;
  logic [2:0] asel = 3'h0;
  logic [15:0] rd_data = 16'h0000;
  ash_pins_t pins;
  ash_reg_req_t req;
  ash_iface_t iface;
  ash_reg_req_t reqq[$];
  int errors = 0, total_checks = 0, swr_cnt = 0, oe_cnt = 0;
  always #12.5 core_clk = ~core_clk;
  ash_host_port dut (.core_clk_in(core_clk), .reset_in(reset), .link_pins_in(pins),
    .readback_output_enable_in(rbe), .output_edge_select_in(oes), .gpio_sdo_map_in(gmap),
    .address_select_pin_in(asel), .rd_data_in(rd_data), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .sda_out(sda),
    .sda_oe_out(sda_oe), .reg_req_out(req), .sw_reset_out(swr), .iface_out(iface));
  ash_host_model host (.core_clk_in(core_clk), .sdo_in(sdo), .sdo_oe_in(sdo_oe), .sda_oe_in(sda_oe), .pins_out(pins));
  function automatic logic [15:0] rdv(input logic [6:0] a);
    return {a, 2'b10, ~a};
  endfunction
  always @(posedge core_clk) begin
    rd_data <= rdv(req.addr);
    if (req.wr === 1'b1 || req.rd === 1'b1) reqq.push_back(req);
    if (swr === 1'b1) swr_cnt++;
    if (sdo_oe === 1'b1) oe_cnt++;
    if (sda_oe === 1'b1) chk_val(24'(sda), 24'h00_0000, "sda drive level");
  end
  task automatic fail(input string m);
    errors++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string m);
    total_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask
  task automatic chk_req(input logic rd, input logic [6:0] a, input logic [15:0] d);
    ash_reg_req_t r;
    total_checks++;
    if (reqq.size() == 0) begin
      fail("request missing");
      return;
    end
    r = reqq.pop_front();
    if (r.rd !== rd || r.wr !== ~rd || r.addr !== a || (!rd && r.data !== d)) fail("request mismatch");
  endtask
  task automatic chk_none();
    chk_val(24'(reqq.size()), 24'h00_0000, "unexpected request");
    reqq.delete();
  endtask
  task automatic rst();
    reset <= 1'b1;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    end_of_test();
  end
  initial begin
    logic [23:0] rx, d;
    logic a0, a1, a2, a3;
    logic [7:0] b0, b1;
    int hp;
    int ob;
    void'($urandom(32'h4564_df46));
    rst();
    chk_val(iface, ASH_IF_NONE, "iface reset");
    d = {1'b0, 23'($urandom)};
    host.spi(d, 24, 0, 4, rx);
    chk_req(1'b0, d[22:16], d[15:0]);
    chk_val(iface, ASH_IF_SPI, "spi lock");
    host.spi(d, 23, 0, 4, rx);
    chk_none();
    d = {1'b0, 23'($urandom)};
    host.spi(d, 30, 0, 4, rx);
    chk_req(1'b0, d[22:16], d[15:0]);
    chk_val(24'(oe_cnt), 24'h00_0000, "sdo driven");
    host.istart(1'b0, 8);
    host.iwr({4'h9, asel, 1'b0}, 8, a0);
    host.istop(8);
    chk_val(24'(a0), 24'h00_0000, "i2c after spi lock");
    chk_none();
    rbe <= 1'b1;
    gmap <= 1'b1;
    // slow sclk on reads leaves room for the pin synchroniser lag
    for (int m = 0; m < 2; m++) begin
      oes <= m[0];
      d = {1'b1, 7'($urandom), 16'($urandom)};
      host.spi(d, 24, 0, 8, rx);
      chk_req(1'b1, d[22:16], 16'h0000);
      host.spi({1'b1, ~d[22:16], 16'h0000}, 24, 0, 8, rx);
      chk_val(rx, {1'b1, d[22:16], rdv(d[22:16])}, "readback");
      chk_req(1'b1, ~d[22:16], 16'h0000);
      chk_val(24'(sdo_oe), 24'h00_0000, "sdo idle");
    end
    d = {1'b0, 23'($urandom)};
    host.spi(d, 48, 24, 4, rx);
    chk_req(1'b0, d[22:16], d[15:0]);
    host.spi(d, 40, 16, 4, rx);
    chk_none();
    gmap <= 1'b0;
    ob = oe_cnt;
    host.spi(d, 30, 0, 4, rx);
    chk_req(1'b0, d[22:16], d[15:0]);
    chk_val(24'(oe_cnt - ob), 24'h00_0000, "sdo without gpio map");
    rst();
    asel <= 3'($urandom);
    for (int s = 0; s < 2; s++) begin
      hp = 8 + 4 * s;
      d = {1'b0, 23'($urandom)};
      host.istart(1'b0, hp);
      host.iwr({4'h9, asel, 1'b0}, hp, a0);
      host.iwr({1'b0, d[22:16]}, hp, a1);
      host.iwr(d[15:8], hp, a2);
      host.iwr(d[7:0], hp, a3);
      chk_none();
      host.istop(hp);
      chk_val(24'({a0, a1, a2, a3}), 24'h00_000f, "write acks");
      chk_req(1'b0, d[22:16], d[15:0]);
    end
    chk_val(iface, ASH_IF_I2C, "i2c lock");
    for (int i = 0; i < 8; i++) begin
      b1 = i[0] ? 8'hf0 : {4'h9, asel ^ 3'(i + 1), 1'b0};
      host.istart(1'b0, 8);
      host.iwr(b1, 8, a0);
      host.istop(8);
      chk_val(24'(a0), 24'h00_0000, "foreign address acked");
    end
    chk_none();
    d[22:16] = 7'($urandom);
    host.istart(1'b0, 8);
    host.iwr({4'h9, asel, 1'b0}, 8, a0);
    host.iwr({1'b0, d[22:16]}, 8, a1);
    host.istart(1'b1, 8);
    host.iwr({4'h9, asel, 1'b1}, 8, a2);
    host.ird(1'b1, 8, b0);
    host.ird(1'b0, 8, b1);
    host.istop(8);
    chk_val(24'({a0, a1, a2}), 24'h00_0007, "read acks");
    chk_req(1'b1, d[22:16], 16'h0000);
    chk_val(24'({b0, b1}), 24'(rdv(d[22:16])), "i2c read data");
    for (int g = 0; g < 2; g++) begin
      host.istart(1'b0, 8);
      host.iwr(8'h00, 8, a0);
      host.iwr(g[0] ? 8'h06 : 8'h05, 8, a1);
      chk_val(24'(swr_cnt), 24'(g), "soft reset count");
      host.istop(8);
      chk_val(24'({a0, a1}), 24'({1'b1, g[0]}), "general call acks");
    end
    host.spi(d, 24, 0, 4, rx);
    chk_none();
    chk_val(iface, ASH_IF_I2C, "lock kept");
    end_of_test();
  end
endmodule
`default_nettype wire
